// ==== logic/hri_cfg.svh ====
// constants of the host register interface: offsets, field positions, reset values
// assumes inclusion by bare name from the top module
`ifndef HRI_CFG_SVH
`define HRI_CFG_SVH
`define HRI_RST_VAL 8'h00
`define HRI_ACB_RW_BIT 0
`define HRI_ACB_ADR_LSB 1
`define HRI_ACB_ADR_MSB 5
`define HRI_BITS_LAST 3'h7
`define HRI_ADR_REV 5'h00
`define HRI_ADR_ALOOP 5'h01
`define HRI_ADR_RLOOP 5'h02
`define HRI_ADR_ONES 5'h03
`define HRI_ADR_LOSS_ST 5'h04
`define HRI_ADR_FAULT_ST 5'h05
`define HRI_ADR_LOSS_EN 5'h06
`define HRI_ADR_FAULT_EN 5'h07
`define HRI_ADR_LOSS_FL 5'h08
`define HRI_ADR_FAULT_FL 5'h09
`define HRI_ADR_SRESET 5'h0A
`define HRI_ADR_MONSEL 5'h0B
`define HRI_ADR_DLOOP 5'h0C
`define HRI_ADR_LOSS_ALARM_MODE_ENABLE 5'h0D
`define HRI_ADR_AUTO1 5'h0E
`define HRI_ADR_GLOBAL 5'h0F
`define HRI_ADR_LLCH 5'h10
`define HRI_ADR_LLVAL 5'h11
`define HRI_ADR_DRVDIS 5'h12
`define HRI_ADR_AIS_ST 5'h13
`define HRI_ADR_AIS_EN 5'h14
`define HRI_ADR_AIS_FL 5'h15
`define HRI_ADR_WBCAST 5'h16
`define HRI_ADR_WPTR 5'h17
`define HRI_ADR_WSAMP 5'h18
`define HRI_ADR_WEN 5'h19
`define HRI_ADR_WOV_EN 5'h1A
`define HRI_ADR_WOV_FL 5'h1B
`define HRI_ADR_SPARE_A 5'h1C
`define HRI_ADR_SPARE_RO 5'h1D
`define HRI_ADR_TCLK_EN 5'h1E
`define HRI_ADR_SPARE_B 5'h1F
`endif

// ==== logic/hri_pkg.sv ====
// types of the host register interface
// assumes hri_cfg.svh is on the include path
package hri_pkg;
	// serial engine states
	typedef enum logic [2:0] {SER_IDLE, SER_CMD, SER_WDATA, SER_READ, SER_DONE} hri_ser_state_type;

	// line-side status inputs, one bit per channel
	typedef struct packed {
		logic [7:0] waveform_overflow;
		logic [7:0] alarm_signal;
		logic [7:0] driver_fault;
		logic [7:0] signal_loss;
	} hri_status_type;

	// control outputs toward the channels
	typedef struct packed {
		logic [7:0] analog_loop;
		logic [7:0] remote_loop;
		logic [7:0] all_ones_transmit;
		logic [7:0] monitor_select;
		logic [7:0] digital_loop;
		logic [7:0] loss_alarm_mode;
		logic [7:0] auto_all_ones;
		logic [7:0] global_settings;
		logic [7:0] line_length_channel;
		logic [7:0] line_length_value;
		logic [7:0] driver_disable;
		logic [7:0] waveform_broadcast;
		logic [7:0] waveform_pointer;
		logic [7:0] waveform_sample;
		logic [7:0] waveform_enable;
		logic [7:0] timing_clock_enable;
	} hri_ctrl_type;
endpackage

// ==== logic/hri_top.sv ====
// host register interface: serial and parallel host ports onto a 32-byte register set
// assumes all pins asynchronous to clk; tri-state pins resolved outside from the enables
`timescale 1ns/100ps
`default_nettype none
`include "hri_cfg.svh"

module hri_top #(
	parameter logic [7:0] REVISION_ID = 8'h5A // arbitrary value
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// mode straps
	input wire logic mode_sense_high,
	input wire logic mode_sense_low,
	// serial port
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_data_in,
	input wire logic output_edge_select,
	// parallel port controls
	input wire logic bus_style_select,
	input wire logic addr_data_share_select,
	input wire logic address_strobe_low,
	input wire logic write_strobe_low,
	input wire logic read_strobe_or_dir,
	// parallel address and data
	input wire logic [4:0] par_addr,
	input wire logic [7:0] data_in,
	output var logic [7:0] data_out,
	output var logic data_oe,
	// shared serial output / handshake pin
	output var logic serial_data_out,
	output var logic serial_data_oe,
	// line side
	input wire hri_pkg::hri_status_type line_status,
	output var hri_pkg::hri_ctrl_type line_ctrl,
	output var logic int_n
);

	//--------------------------------------------------
	// input synchronisers
	//--------------------------------------------------
	localparam int SW = 56;
	logic [SW-1:0] raw;
	logic [SW-1:0] sync1_ff;
	logic [SW-1:0] sync2_ff;
	logic [SW-1:0] sync3_ff;
	assign raw = {line_status, data_in, par_addr, mode_sense_high, mode_sense_low, cs_n, sclk,
		serial_data_in, output_edge_select, bus_style_select, addr_data_share_select,
		address_strobe_low, write_strobe_low, read_strobe_or_dir};

	// two flops then one for edge finding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	logic [31:0] stat_s;
	logic [7:0] din_s;
	logic [4:0] paddr_s;
	logic mode_hi, mode_lo, cs_s, sdi_s, edge_sel, style_s, share_s, strb_a, strb_b;
	logic sclk_rise, sclk_fall, ale_fall;
	assign {stat_s, din_s, paddr_s, mode_hi, mode_lo, cs_s} = sync2_ff[SW-1:8];
	assign sdi_s = sync2_ff[6];
	assign edge_sel = sync2_ff[5];
	assign style_s = sync2_ff[4];
	assign share_s = sync2_ff[3];
	assign strb_a = sync2_ff[1];
	assign strb_b = sync2_ff[0];
	assign sclk_rise = sync2_ff[7] & ~sync3_ff[7];
	assign sclk_fall = ~sync2_ff[7] & sync3_ff[7];
	assign ale_fall = ~sync2_ff[2] & sync3_ff[2];

	// port selection from the mode strap
	logic ser_mode, par_mode;
	assign ser_mode = ~mode_hi & ~mode_lo;
	assign par_mode = mode_hi;

	//--------------------------------------------------
	// register access path
	//--------------------------------------------------
	logic soft_rst_ff;
	logic ser_wr, ser_rd, par_wr, par_rd;
	logic [4:0] ser_waddr, ser_raddr, par_addr_eff;
	logic [7:0] ser_wdata, par_wdata;
	logic acc_wr, acc_rd;
	logic [4:0] acc_waddr, acc_raddr;
	logic [7:0] acc_wdata, rd_data;
	logic [7:0] rw_ff [32];
	logic [3:0][7:0] flag_ff;
	logic [3:0][7:0] prev_ff;

	// only one port is live at a time
	assign acc_wr = ser_mode ? ser_wr : par_wr;
	assign acc_rd = ser_mode ? ser_rd : par_rd;
	assign acc_waddr = ser_mode ? ser_waddr : par_addr_eff;
	assign acc_raddr = ser_mode ? ser_raddr : par_addr_eff;
	assign acc_wdata = ser_mode ? ser_wdata : par_wdata;

	// read mux over the map
	always_comb begin
		rd_data = rw_ff[acc_raddr];
		unique case (acc_raddr)
			`HRI_ADR_REV: rd_data = REVISION_ID;
			`HRI_ADR_LOSS_ST: rd_data = stat_s[7:0];
			`HRI_ADR_FAULT_ST: rd_data = stat_s[15:8];
			`HRI_ADR_AIS_ST: rd_data = stat_s[23:16];
			`HRI_ADR_LOSS_FL: rd_data = flag_ff[0];
			`HRI_ADR_FAULT_FL: rd_data = flag_ff[1];
			`HRI_ADR_AIS_FL: rd_data = flag_ff[2];
			`HRI_ADR_WOV_FL: rd_data = flag_ff[3];
			`HRI_ADR_SPARE_RO: rd_data = `HRI_RST_VAL;
			default: rd_data = rw_ff[acc_raddr];
		endcase
	end

	// soft reset pulse after a write to its register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst_ff <= 1'b0;
		end else begin
			soft_rst_ff <= acc_wr && (acc_waddr == `HRI_ADR_SRESET);
		end
	end

	// writable bytes; read-only addresses never store
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_rw
			localparam logic [4:0] A = 5'(gi);
			localparam bit RO = (A == `HRI_ADR_REV) || (A == `HRI_ADR_LOSS_ST) || (A == `HRI_ADR_FAULT_ST) ||
				(A == `HRI_ADR_LOSS_FL) || (A == `HRI_ADR_FAULT_FL) || (A == `HRI_ADR_AIS_ST) ||
				(A == `HRI_ADR_AIS_FL) || (A == `HRI_ADR_WOV_FL) || (A == `HRI_ADR_SPARE_RO);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					rw_ff[gi] <= `HRI_RST_VAL;
				end else if (soft_rst_ff) begin
					rw_ff[gi] <= `HRI_RST_VAL;
				end else if (!RO && acc_wr && acc_waddr == A) begin
					rw_ff[gi] <= acc_wdata;
				end
			end
		end
	endgenerate

	//--------------------------------------------------
	// change flags and interrupt
	//--------------------------------------------------
	localparam logic [4:0] FLAG_ADR [4] = '{`HRI_ADR_LOSS_FL, `HRI_ADR_FAULT_FL, `HRI_ADR_AIS_FL, `HRI_ADR_WOV_FL};
	localparam logic [4:0] EN_ADR [4] = '{`HRI_ADR_LOSS_EN, `HRI_ADR_FAULT_EN, `HRI_ADR_AIS_EN, `HRI_ADR_WOV_EN};
	logic [3:0] grp_irq;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			logic [7:0] chg;
			assign chg = stat_s[gi*8 +: 8] ^ prev_ff[gi];
			// set on change wins over clear on read
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					prev_ff[gi] <= `HRI_RST_VAL;
					flag_ff[gi] <= `HRI_RST_VAL;
				end else begin
					prev_ff[gi] <= stat_s[gi*8 +: 8];
					if (soft_rst_ff) begin
						flag_ff[gi] <= `HRI_RST_VAL;
					end else if (acc_rd && acc_raddr == FLAG_ADR[gi]) begin
						flag_ff[gi] <= chg;
					end else begin
						flag_ff[gi] <= flag_ff[gi] | chg;
					end
				end
			end
			assign grp_irq[gi] = |(flag_ff[gi] & rw_ff[EN_ADR[gi]]);
		end
	endgenerate

	// active-low interrupt
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~(|grp_irq);
		end
	end

	//--------------------------------------------------
	// serial engine
	//--------------------------------------------------
	hri_pkg::hri_ser_state_type ser_state_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff, cmd_ff, out_sh_ff;
	logic [2:0] out_left_ff;
	logic sdo_ff, sdo_oe_ff;
	logic [7:0] shift_nxt;
	logic launch;
	assign shift_nxt = {sdi_s, shift_ff[7:1]};
	assign launch = edge_sel ? sclk_fall : sclk_rise;
	assign ser_raddr = shift_nxt[`HRI_ACB_ADR_MSB:`HRI_ACB_ADR_LSB];
	assign ser_rd = ser_mode && ser_state_ff == hri_pkg::SER_CMD && sclk_rise && bit_cnt_ff == `HRI_BITS_LAST &&
		shift_nxt[`HRI_ACB_RW_BIT];
	assign ser_wr = ser_mode && ser_state_ff == hri_pkg::SER_WDATA && sclk_rise && bit_cnt_ff == `HRI_BITS_LAST;
	assign ser_waddr = cmd_ff[`HRI_ACB_ADR_MSB:`HRI_ACB_ADR_LSB];
	assign ser_wdata = shift_nxt;

	// state and input shifting; input shifts on sampled serial clock rises, idle leaves on select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_state_ff <= hri_pkg::SER_IDLE;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			cmd_ff <= 8'h00;
		end else if (soft_rst_ff || !ser_mode || cs_s) begin
			ser_state_ff <= hri_pkg::SER_IDLE;
			bit_cnt_ff <= 3'h0;
		end else begin
			unique case (ser_state_ff)
				hri_pkg::SER_IDLE: begin
					ser_state_ff <= hri_pkg::SER_CMD;
				end
				hri_pkg::SER_CMD: begin
					if (sclk_rise) begin
						shift_ff <= shift_nxt;
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == `HRI_BITS_LAST) begin
							cmd_ff <= shift_nxt;
							ser_state_ff <= shift_nxt[`HRI_ACB_RW_BIT] ? hri_pkg::SER_READ : hri_pkg::SER_WDATA;
						end
					end
				end
				hri_pkg::SER_WDATA: begin
					if (sclk_rise) begin
						shift_ff <= shift_nxt;
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == `HRI_BITS_LAST) begin
							ser_state_ff <= hri_pkg::SER_DONE;
						end
					end
				end
				hri_pkg::SER_READ: begin
					if (!sdo_oe_ff && out_left_ff == 3'h0 && launch && !ser_rd) begin
						ser_state_ff <= hri_pkg::SER_DONE;
					end
				end
				hri_pkg::SER_DONE: begin
					bit_cnt_ff <= 3'h0;
				end
			endcase
		end
	end

	// read data launch; lowest bit first, float when idle
	logic rd_armed_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_ff <= 1'b0;
			sdo_oe_ff <= 1'b0;
			out_sh_ff <= 8'h00;
			out_left_ff <= 3'h0;
			rd_armed_ff <= 1'b0;
		end else if (soft_rst_ff || !ser_mode || cs_s) begin
			sdo_oe_ff <= 1'b0;
			rd_armed_ff <= 1'b0;
			out_left_ff <= 3'h0;
		end else if (ser_rd && !edge_sel) begin
			sdo_ff <= rd_data[0];
			sdo_oe_ff <= 1'b1;
			out_sh_ff <= rd_data;
			out_left_ff <= `HRI_BITS_LAST;
		end else if (ser_rd) begin
			out_sh_ff <= rd_data;
			rd_armed_ff <= 1'b1;
		end else if (launch && rd_armed_ff) begin
			sdo_ff <= out_sh_ff[0];
			sdo_oe_ff <= 1'b1;
			out_left_ff <= `HRI_BITS_LAST;
			rd_armed_ff <= 1'b0;
		end else if (launch && sdo_oe_ff) begin
			if (out_left_ff == 3'h0) begin
				sdo_oe_ff <= 1'b0;
			end else begin
				out_sh_ff <= {1'b0, out_sh_ff[7:1]};
				sdo_ff <= out_sh_ff[1];
				out_left_ff <= out_left_ff - 3'h1;
			end
		end
	end

	//--------------------------------------------------
	// parallel engine
	//--------------------------------------------------
	logic cs_act, rd_act, wr_act;
	logic cs_act_q_ff, rd_act_q_ff, wr_act_q_ff;
	logic [4:0] lat_addr_ff;
	logic [7:0] wr_hold_ff;
	logic hs_ff, hs_oe_ff;
	assign cs_act = par_mode & ~cs_s & ~soft_rst_ff;
	// style high: a is write, b is read; low: a is data strobe, b is direction
	assign rd_act = cs_act & (style_s ? ~strb_b : (~strb_a & strb_b));
	assign wr_act = cs_act & (style_s ? ~strb_a : (~strb_a & ~strb_b));
	assign par_addr_eff = share_s ? lat_addr_ff : paddr_s;
	assign par_rd = rd_act & ~rd_act_q_ff;
	assign par_wr = wr_act_q_ff & ~wr_act & par_mode;
	assign par_wdata = wr_hold_ff;

	// strobe history, address latch and write data hold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_act_q_ff <= 1'b0;
			rd_act_q_ff <= 1'b0;
			wr_act_q_ff <= 1'b0;
			lat_addr_ff <= 5'h00;
			wr_hold_ff <= 8'h00;
		end else begin
			cs_act_q_ff <= cs_act;
			rd_act_q_ff <= rd_act;
			wr_act_q_ff <= wr_act;
			if (ale_fall && par_mode) begin
				lat_addr_ff <= din_s[4:0];
			end
			if (wr_act) begin
				wr_hold_ff <= din_s;
			end
		end
	end

	// read data drive, released as the strobe rises
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
		end else if (par_rd) begin
			data_out <= rd_data;
			data_oe <= 1'b1;
		end else if (!rd_act) begin
			data_oe <= 1'b0;
		end
	end

	// ready / acknowledge handshake
	logic xfer_done;
	assign xfer_done = par_wr | (rd_act_q_ff & ~rd_act);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_ff <= 1'b0;
			hs_oe_ff <= 1'b0;
		end else if (!par_mode) begin
			hs_ff <= 1'b0;
			hs_oe_ff <= 1'b0;
		end else if (style_s) begin
			if (cs_act && !cs_act_q_ff) begin
				hs_ff <= 1'b0;
				hs_oe_ff <= 1'b1;
			end else if (!cs_act) begin
				hs_oe_ff <= 1'b0;
			end else if (xfer_done) begin
				hs_ff <= 1'b1;
			end
		end else begin
			hs_oe_ff <= 1'b1;
			if (share_s ? (ale_fall && cs_act) : (cs_act && !cs_act_q_ff)) begin
				hs_ff <= 1'b1;
			end else if (xfer_done || !cs_act) begin
				hs_ff <= 1'b0;
			end
		end
	end

	//--------------------------------------------------
	// shared output pin and control outputs
	//--------------------------------------------------
	assign serial_data_out = ser_mode ? sdo_ff : hs_ff;
	assign serial_data_oe = ser_mode ? sdo_oe_ff : hs_oe_ff;
	assign line_ctrl = '{analog_loop: rw_ff[`HRI_ADR_ALOOP], remote_loop: rw_ff[`HRI_ADR_RLOOP],
		all_ones_transmit: rw_ff[`HRI_ADR_ONES], monitor_select: rw_ff[`HRI_ADR_MONSEL],
		digital_loop: rw_ff[`HRI_ADR_DLOOP], loss_alarm_mode: rw_ff[`HRI_ADR_LOSS_ALARM_MODE_ENABLE],
		auto_all_ones: rw_ff[`HRI_ADR_AUTO1], global_settings: rw_ff[`HRI_ADR_GLOBAL],
		line_length_channel: rw_ff[`HRI_ADR_LLCH], line_length_value: rw_ff[`HRI_ADR_LLVAL],
		driver_disable: rw_ff[`HRI_ADR_DRVDIS], waveform_broadcast: rw_ff[`HRI_ADR_WBCAST],
		waveform_pointer: rw_ff[`HRI_ADR_WPTR], waveform_sample: rw_ff[`HRI_ADR_WSAMP],
		waveform_enable: rw_ff[`HRI_ADR_WEN], timing_clock_enable: rw_ff[`HRI_ADR_TCLK_EN]};

endmodule // hri_top
`default_nettype wire

// ==== verif/hri_top_assertions.sv ====
// port checker of the host register interface
// assumes bind onto hri_top; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module hri_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// straps, select, strobes
	input wire logic mode_sense_high,
	input wire logic mode_sense_low,
	input wire logic cs_n,
	input wire logic bus_style_select,
	input wire logic write_strobe_low,
	input wire logic read_strobe_or_dir,
	// driven outputs
	input wire logic data_oe,
	input wire logic serial_data_oe,
	input wire logic serial_data_out,
	input wire logic int_n
);
	logic ser_m, sep_m, strb_m;
	// decoded strap modes
	assign ser_m = !mode_sense_high && !mode_sense_low;
	assign sep_m = mode_sense_high && !mode_sense_low && bus_style_select;
	assign strb_m = mode_sense_high && !mode_sense_low && !bus_style_select;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// port relations
	// ----
	a_ser_out_float: assert property ((ser_m && cs_n) [*8] |-> !serial_data_oe)
		else $error("serial output driven while deselected");
	a_bus_quiet_ser: assert property (ser_m [*8] |-> !data_oe)
		else $error("parallel bus driven in serial mode");
	a_ready_idle_float: assert property ((sep_m && cs_n) [*8] |-> !serial_data_oe)
		else $error("ready driven while idle");
	a_ready_low_sel: assert property (sep_m && $fell(cs_n) |-> ##[1:6] (serial_data_oe && !serial_data_out))
		else $error("ready not low after select");
	a_ack_driven: assert property (strb_m [*8] |-> serial_data_oe)
		else $error("acknowledge not driven");
	a_read_drive: assert property ((sep_m && !cs_n && !read_strobe_or_dir) [*6] |-> data_oe)
		else $error("read data not driven");
	a_read_release: assert property ((sep_m && read_strobe_or_dir) [*5] |-> !data_oe)
		else $error("bus held after read strobe");
	a_strobe_drive: assert property ((strb_m && !cs_n && !write_strobe_low && read_strobe_or_dir) [*6]
		|-> data_oe) else $error("data strobe read not driven");
	a_strobe_release: assert property ((strb_m && write_strobe_low) [*5] |-> !data_oe)
		else $error("bus held after data strobe");
	// main scenarios seen
	c_ser_read: cover property (ser_m && $rose(serial_data_oe));
	c_par_read: cover property (sep_m && $rose(data_oe));
	c_irq: cover property ($fell(int_n));
endmodule // hri_chk
bind hri_top hri_chk hri_chk_inst (.clk(clk), .rst_n(rst_n), .mode_sense_high(mode_sense_high),
	.mode_sense_low(mode_sense_low), .cs_n(cs_n), .bus_style_select(bus_style_select),
	.write_strobe_low(write_strobe_low), .read_strobe_or_dir(read_strobe_or_dir), .data_oe(data_oe),
	.serial_data_oe(serial_data_oe), .serial_data_out(serial_data_out), .int_n(int_n));
`default_nettype wire

// ==== verif/hri_host_model.sv ====
// serial host master driving the register port
// assumes the device output arrives resolved, z while floating
`timescale 1ns/100ps
`default_nettype none
module hri_host_model (
	// from the device
	input wire logic dev_out,
	input wire logic edge_sel,
	// host pins
	output var logic cs_n,
	output var logic sclk,
	output var logic host_in
);
	// parked: deselected, clock still
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		host_in = 1'b0;
	end
	// one access, 125 ns clock; fewer than 16 bits aborts it
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] w, input int n, output logic [7:0] r);
		logic [15:0] sh;
		sh = {w, cmd};
		r = 8'h00;
		cs_n = 1'b0;
		#62.5;
		for (int j = 0; j < n; j++) begin
			sclk = 1'b0;
			if (j >= 8 && !edge_sel) r[j - 8] = dev_out;
			host_in = (cmd[0] && j >= 8) ? ~host_in : sh[j];
			#62.5;
			sclk = 1'b1;
			if (j >= 8 && edge_sel) r[j - 8] = dev_out;
			#62.5;
		end
		sclk = 1'b0;
		host_in = ~host_in;
		#62.5;
		cs_n = 1'b1;
		#62.5;
	endtask
endmodule // hri_host_model
`default_nettype wire

// ==== verif/host_register_interface_tb.sv ====
// self-checking bench of both host ports
// assumes hri_host_model as serial host, checker bound
`timescale 1ns/100ps
`default_nettype none
module host_register_interface_tb;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	localparam logic [31:0] RW_MAP = 32'hD7D7F8CE;
	logic clk, rst_n, mode_hi, mode_lo, edge_sel, style, share, alat_n, wr_n, rd_n, pcs_n;
	logic doe, hout, hoe, int_n, sclk, hin, mcs_n;
	logic [4:0] paddr;
	logic [7:0] din, dout, rd;
	hri_pkg::hri_status_type stat;
	hri_pkg::hri_ctrl_type ctrl;
	int miscompares, num_checks;
	wire logic cs_w;
	wire logic hdout;
	// shared select, resolved output pin
	assign cs_w = pcs_n & mcs_n;
	assign hdout = hoe ? hout : 1'bz;
	hri_top #(.REVISION_ID(REV)) hri_top_inst (.clk(clk), .rst_n(rst_n), .mode_sense_high(mode_hi),
		.mode_sense_low(mode_lo), .cs_n(cs_w), .sclk(sclk), .serial_data_in(hin), .output_edge_select(edge_sel),
		.bus_style_select(style), .addr_data_share_select(share), .address_strobe_low(alat_n),
		.write_strobe_low(wr_n), .read_strobe_or_dir(rd_n), .par_addr(paddr), .data_in(din),
		.data_out(dout), .data_oe(doe), .serial_data_out(hout), .serial_data_oe(hoe),
		.line_status(stat), .line_ctrl(ctrl), .int_n(int_n));
	hri_host_model hri_host_model_inst (.dev_out(hdout), .edge_sel(edge_sel), .cs_n(mcs_n), .sclk(sclk),
		.host_in(hin));
	// clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----
	// tasks
	// ----
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// serial access through the host model
	task automatic ser(input logic [4:0] a, input logic rdop, input logic [7:0] w, input int n,
		input logic [7:0] exp);
		logic [7:0] r;
		hri_host_model_inst.xfer({2'b11, a, rdop}, w, n, r);
		tick(6);
		if (rdop && n == 16) chk(r, exp);
		if (n < 16) chk({7'h0, hoe}, 8'h00);
	endtask
	// parallel access in the current style and sharing
	task automatic par(input logic wr, input logic [4:0] a, input logic [7:0] w, output logic [7:0] r);
		if (!style) rd_n = ~wr;
		pcs_n = 1'b0;
		paddr = share ? ~a : a;
		din = {3'h0, a};
		tick(6);
		if (share) begin
			alat_n = 1'b0;
			tick(6);
			alat_n = 1'b1;
			tick(4);
		end
		chk({6'h0, hoe, hout}, style ? 8'h02 : 8'h03);
		din = wr ? w : ~din;
		if (style && !wr) rd_n = 1'b0;
		else wr_n = 1'b0;
		tick(8);
		r = dout;
		chk({7'h0, doe}, {7'h0, ~wr});
		wr_n = 1'b1;
		if (style) rd_n = 1'b1;
		tick(6);
		chk({6'h0, hoe, hout, doe}, style ? 8'h06 : 8'h04);
		pcs_n = 1'b1;
		tick(6);
		if (style) chk({7'h0, hoe}, 8'h00);
	endtask
	task automatic wait_low;
		int k;
		k = 0;
		while (int_n !== 1'b0 && k < 40) begin
			tick(1);
			k++;
		end
		chk({7'h0, int_n}, 8'h00);
		if (k == 40) complete_run;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{rst_n, mode_hi, edge_sel, share, pcs_n, alat_n, wr_n, rd_n, style} = 9'h01F;
		mode_lo = 1'b0;
		paddr = 5'h00;
		din = 8'h00;
		stat = '0;
		miscompares = 0;
		num_checks = 0;
		tick(12);
		rst_n = 1'b1;
		tick(4);
		for (int a = 0; a < 32; a++) ser(5'(a), 1'b1, 8'h00, 16, a == 0 ? REV : 8'h00);
		$display("reset values done");
		for (int e = 0; e < 2; e++) begin
			edge_sel = e[0];
			for (int a = 0; a < 32; a++) if (a != 10) ser(5'(a), 1'b0, 8'(a * 7 + e), 16, 8'h00);
			for (int a = 0; a < 32; a++) if (a != 10) ser(5'(a), 1'b1, 8'h00, 16,
				a == 0 ? REV : (RW_MAP[a] ? 8'(a * 7 + e) : 8'h00));
		end
		chk(ctrl.timing_clock_enable, 8'hD3);
		$display("write and read back done");
		ser(5'h01, 1'b0, 8'h5A, 12, 8'h00);
		ser(5'h01, 1'b1, 8'h00, 11, 8'h00);
		ser(5'h01, 1'b1, 8'h00, 16, 8'h08);
		ser(5'h0A, 1'b0, 8'hFF, 16, 8'h00);
		ser(5'h01, 1'b1, 8'h00, 16, 8'h00);
		ser(5'h1E, 1'b1, 8'h00, 16, 8'h00);
		$display("abort and soft reset done");
		ser(5'h06, 1'b0, 8'h01, 16, 8'h00);
		stat.signal_loss = 8'h01;
		wait_low();
		ser(5'h04, 1'b1, 8'h00, 16, 8'h01);
		ser(5'h08, 1'b1, 8'h00, 16, 8'h01);
		tick(4);
		chk({7'h0, int_n}, 8'h01);
		stat.signal_loss = 8'h03;
		tick(20);
		chk({7'h0, int_n}, 8'h01);
		ser(5'h08, 1'b1, 8'h00, 16, 8'h02);
		$display("interrupt done");
		// hardware strap: serial port must ignore the access
		mode_lo = 1'b1;
		tick(4);
		ser(5'h02, 1'b0, 8'hA5, 16, 8'h00);
		mode_lo = 1'b0;
		tick(4);
		ser(5'h02, 1'b1, 8'h00, 16, 8'h00);
		$display("hardware strap done");
		mode_hi = 1'b1;
		for (int m = 0; m < 4; m++) begin
			style = m[0];
			share = m[1];
			rd_n = 1'b1;
			tick(10);
			par(1'b1, 5'h1E, 8'(m + 64), rd);
			par(1'b0, 5'h1E, 8'h00, rd);
			chk(rd, 8'(m + 64));
			par(1'b0, 5'h04, 8'h00, rd);
			chk(rd, 8'h03);
			$display("parallel style %0d share %0d done", style, share);
		end
		complete_run();
	end
endmodule // host_register_interface_tb
`default_nettype wire
